// ### bench/pic_src_model.sv
// Peripheral request source that holds its level request until told to drop it
module pic_src_model (
  input  wire logic       clk,    // System clock
  input  wire logic       reset,  // Synchronous reset
  input  wire logic [1:0] raise,  // Start a request
  input  wire logic [1:0] drop,   // Withdraw a request
  output logic      [1:0] req     // Level requests
);
  timeunit 1ns;
  timeprecision 1ps;
  // Controller has no clear for level requests, so only the source lowers them
  always_ff @(posedge clk)
  begin
    if (reset)
      req <= 2'h0;
    else
      req <= (req | raise) & ~drop;
  end
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the interrupt controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, reset = 1'b1;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic        s_axi_awvalid = 1'b0, aw_from_core = 1'b1, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, periph_req, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, bs, src_req, raise = 2'h0, drop = 2'h0;
  logic [5:0]  ext_int_pin = 6'h0;
  logic        network_ctrl_a_req = 1'b0, network_ctrl_b_req = 1'b0, boot_data7 = 1'b0;
  logic [1:0]  pin_mux_net = 2'h0;
  logic        core_timer_irq = 1'b0, ext_arbiter_mode = 1'b0;
  logic [7:2]  core_pending_bits;
  logic        soft_req_pin_out, soft_req_pin_oe, soft_int_req;
  int          fails = 0, check_count = 0;
  logic [15:0] row_a [4] = '{16'hF600, 16'hF640, 16'hF660, 16'hF510};
  logic [31:0] row_d [4] = '{32'h1, 32'h5, 32'hFFFF, 32'hA5A5};
  logic [31:0] row_e [4] = '{32'h1, 32'h5, 32'h0, 32'hA5A5};
  // Sources 8 and 9 come from the partner model
  assign periph_req = {22'h0, src_req, 8'h00};
  always #2 clk = ~clk;
  pic_top u_pic_top (.*);
  pic_src_model u_pic_src_model (.clk(clk), .reset(reset), .raise(raise), .drop(drop),
    .req(src_req));
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic c);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    aw_from_core <= c;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    bs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50)
    begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic rdr(input logic [15:0] a);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50)
    begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    rdr(16'hF6A0); check(rd, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(row_a[i], row_d[i], 1'b1);
      check(bs, 32'h0);
      rdr(row_a[i]); check(rd, row_e[i]);
    end
    wr(16'hF640, 32'h0, 1'b1);
    wr(16'hF604, 32'h0005_0000, 1'b1);
    wr(16'hF618, 32'h0000_0303, 1'b1);
    @(posedge clk) raise <= 2'h3;
    @(posedge clk) raise <= 2'h0;
    settle();
    rdr(16'hF680); check(rd & 32'h300, 32'h300);
    rdr(16'hF6A0); check(rd, 32'h0001_0308);
    check(core_pending_bits, 6'h11);
    wr(16'hF640, 32'h3, 1'b1); settle();
    rdr(16'hF6A0); check(rd, 32'h0000_0308);
    wr(16'hF640, 32'h0, 1'b1);
    wr(16'hF618, 32'h0000_0503, 1'b1); settle();
    rdr(16'hF6A0); check(rd, 32'h0001_0509);
    wr(16'hF618, 32'h0000_0103, 1'b1); settle();
    rdr(16'hF6A0); check(rd, 32'h0001_0308);
    @(posedge clk) drop <= 2'h1;
    core_timer_irq <= 1'b1;
    @(posedge clk) drop <= 2'h0;
    settle();
    rdr(16'hF6A0); check(rd, 32'h0001_0109);
    check(core_pending_bits, 6'h33);
    wr(16'hF600, 32'h0, 1'b1); settle();
    rdr(16'hF680); check(rd & 32'h300, 32'h0);
    wr(16'hF51C, 32'h0, 1'b1);
    wr(16'hF510, 32'h1, 1'b1);
    wr(16'hF518, 32'h0, 1'b1);
    wr(16'hF520, 32'h1, 1'b1);
    ext_arbiter_mode <= 1'b1;
    wr(16'hF524, 32'h1, 1'b1); settle();
    check(soft_int_req, 1'b1);
    check({soft_req_pin_out, soft_req_pin_oe}, 2'h3);
    // Open drain never drives high, so a set request leaves the pin released
    wr(16'hF51C, 32'h4, 1'b1); settle();
    check({soft_req_pin_out, soft_req_pin_oe}, 2'h0);
    wr(16'hF514, 32'h2, 1'b1);
    rdr(16'hF510); check(rd, 32'h3);
    wr(16'hF514, 32'h1, 1'b0);
    rdr(16'hF510); check(rd, 32'h2);
    rdr(16'hF700); check(rs, 2'h2);
    wr(16'hF700, 32'h0, 1'b1);
    check(bs, 32'h2);
    // Source 5 from network controller B first, then from the pin as a rising edge
    wr(16'hF604, 32'h0005_0400, 1'b1);
    wr(16'hF614, 32'h0000_0700, 1'b1);
    network_ctrl_b_req <= 1'b1;
    wr(16'hF600, 32'h1, 1'b1);
    settle();
    rdr(16'hF6A0);
    check(rd, 32'h0001_0109);
    pin_mux_net <= 2'h1;
    settle();
    rdr(16'hF6A0);
    check(rd, 32'h0001_0705);
    pin_mux_net <= 2'h0;
    wr(16'hF604, 32'h0005_0C00, 1'b1);
    ext_int_pin <= 6'h08;
    settle();
    rdr(16'hF6A0);
    check(rd, 32'h0001_0705);
    // Edge stays latched after the pin falls, until cleared by number
    ext_int_pin <= 6'h00;
    settle();
    rdr(16'hF6A0);
    check(rd, 32'h0001_0705);
    wr(16'hF660, 32'h0000_0085, 1'b1);
    settle();
    rdr(16'hF6A0);
    check(rd, 32'h0001_0109);
    // Mid-run reset with the strap high: timer request must vanish from bit 7
    boot_data7 <= 1'b1;
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    check(core_pending_bits, 6'h00);
    rdr(16'hF600);
    check(rd, 32'h0);
    wrap_up();
  end
endmodule

// ### hdl/pic_params.svh
// Register offsets, field positions and reset values of the interrupt controller
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
`define PIC_OFS_DETECT_EN     16'hF600
`define PIC_OFS_MODE_LOW      16'hF604
`define PIC_OFS_MODE_HIGH     16'hF608
`define PIC_OFS_LEVEL_FIRST   16'hF610
`define PIC_OFS_LEVEL_LAST    16'hF62C
`define PIC_OFS_GLOBAL_MASK   16'hF640
`define PIC_OFS_EDGE_CLEAR    16'hF660
`define PIC_OFS_PENDING       16'hF680
`define PIC_OFS_CUR_STATUS    16'hF6A0
`define PIC_OFS_FLAG_DIRECT   16'hF510
`define PIC_OFS_FLAG_SETCLR   16'hF514
`define PIC_OFS_FLAG_POL      16'hF518
`define PIC_OFS_SOFT_CTRL     16'hF51C
`define PIC_OFS_MASK_INT      16'hF520
`define PIC_OFS_MASK_EXT      16'hF524
`define PIC_LVL_FIELD_STRIDE  8
`define PIC_CS_LEVEL_LSB      8
`define PIC_CS_FLAG_BIT       16
`define PIC_EDC_SRC_B_LSB     8
`define PIC_EDC_EN_A_BIT      7
`define PIC_EDC_EN_B_BIT      15
`define PIC_CTRL_INTERNAL_OUT_POLARITY_BIT   0
`define PIC_CTRL_EXTERNAL_OUT_POLARITY_BIT   1
`define PIC_CTRL_OD_BIT       2
`define PIC_SRC_RESERVED      20
`define PIC_SRC_SOFT          13
`define PIC_SRC_SHARED_B      5
`define PIC_SRC_SHARED_A      6
`define PIC_RST_WORD          32'h0000_0000
`define PIC_RESP_OKAY         2'h0
`define PIC_RESP_SLVERR       2'h2
`endif

// ### hdl/pic_pkg.sv
// Types shared by the interrupt controller
package pic_pkg;
  typedef enum logic [1:0] {PIC_LOW, PIC_HIGH, PIC_FALL, PIC_RISE} pic_mode_type;
  typedef struct packed {
    logic       valid;
    logic [4:0] cause;
    logic [2:0] level;
  } pic_sel_type;
  typedef struct packed {
    logic [15:0] addr;
    logic        from_core;
  } pic_waddr_type;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
  } pic_wdata_type;
endpackage

// ### hdl/pic_top.sv
// Prioritising interrupt controller with soft request flags and AXI4-Lite registers
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`include "pic_params.svh"
module pic_top (
  input  wire logic        clk,                 // System clock
  input  wire logic        reset,               // Synchronous reset, active high
  input  wire logic [15:0] s_axi_awaddr,        // Write address
  input  wire logic        s_axi_awvalid,       // Write address valid
  output logic             s_axi_awready,       // Write address ready
  input  wire logic        aw_from_core,        // Write issued by the core, with awaddr
  input  wire logic [31:0] s_axi_wdata,         // Write data
  input  wire logic [3:0]  s_axi_wstrb,         // Write byte strobes
  input  wire logic        s_axi_wvalid,        // Write data valid
  output logic             s_axi_wready,        // Write data ready
  output logic [1:0]       s_axi_bresp,         // Write response
  output logic             s_axi_bvalid,        // Write response valid
  input  wire logic        s_axi_bready,        // Write response ready
  input  wire logic [15:0] s_axi_araddr,        // Read address
  input  wire logic        s_axi_arvalid,       // Read address valid
  output logic             s_axi_arready,       // Read address ready
  output logic [31:0]      s_axi_rdata,         // Read data
  output logic [1:0]       s_axi_rresp,         // Read response
  output logic             s_axi_rvalid,        // Read data valid
  input  wire logic        s_axi_rready,        // Read data ready
  input  wire logic [31:0] periph_req,          // On-chip requests by source number
  input  wire logic [5:0]  ext_int_pin,         // External request pins, asynchronous
  input  wire logic        network_ctrl_a_req,  // Network controller A request
  input  wire logic        network_ctrl_b_req,  // Network controller B request
  input  wire logic [1:0]  pin_mux_net,         // Bit 0: source 5, bit 1: source 6 internal
  input  wire logic        boot_data7,          // Data bus bit 7 pin, asynchronous
  input  wire logic        core_timer_irq,      // Core internal timer request
  input  wire logic        ext_arbiter_mode,    // External bus arbiter mode
  output logic [7:2]       core_pending_bits,   // To the core's external pending bits
  output logic             soft_req_pin_out,    // Bus request pin level
  output logic             soft_req_pin_oe,     // Bus request pin output enable
  output logic             soft_int_req         // Internal soft request level
);
  pic_pkg::pic_sel_type  stat_ff;
  pic_pkg::pic_sel_type  best;
  pic_pkg::pic_waddr_type aw_ff;
  pic_pkg::pic_wdata_type w_ff;
  logic                  aw_have_ff;
  logic                  w_have_ff;
  logic                  do_write;
  logic                  nxt_aw_have;
  logic                  nxt_w_have;
  logic                  nxt_rvalid;
  logic                  det_en_ff;
  logic [31:0]           mode_lo_ff;
  logic [31:0]           mode_hi_ff;
  logic [31:0][2:0]      level_ff;
  logic [2:0]            gmask_ff;
  logic [31:0]           pend_ff;
  logic [31:0]           edge_ff;
  logic [31:0]           prev_ff;
  logic [31:0]           src_raw;
  logic [31:0]           lvl_hit;
  logic [31:0]           edge_set;
  logic [31:0]           is_edge;
  logic [31:0]           clr_vec;
  logic [31:0]           elig;
  logic                  rearb;
  logic                  flag_ff;
  logic [5:0]            pin_s1_ff;
  logic [5:0]            pin_s2_ff;
  logic                  boot_s1_ff;
  logic                  boot_s2_ff;
  logic                  tdis_ff;
  logic                  tdis_done_ff;
  logic [15:0]           sflag_ff;
  logic [15:0]           spol_ff;
  logic [15:0]           smask_int_ff;
  logic [15:0]           smask_ext_ff;
  logic [2:0]            sctrl_ff;
  logic                  ext_val;
  logic [31:0]           wmask;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  // Four sources per level register, one byte lane each
  function automatic logic [31:0] lvl_image(input logic [31:0][2:0] lv, input logic [2:0] r);
    logic [31:0] img;
    img = `PIC_RST_WORD;
    for (int k = 0; k < 4; k++)
      img[k*`PIC_LVL_FIELD_STRIDE +: 3] = lv[{r, 2'(k)}];
    return img;
  endfunction

  function automatic logic is_lvl_addr(input logic [15:0] a);
    return a >= `PIC_OFS_LEVEL_FIRST && a <= `PIC_OFS_LEVEL_LAST;
  endfunction

  function automatic logic [2:0] lvl_reg(input logic [15:0] a);
    logic [15:0] d;
    d = a - `PIC_OFS_LEVEL_FIRST;
    return d[4:2];
  endfunction

  function automatic logic [1:0] mode_of(input int i, input logic [31:0] lo,
                                         input logic [31:0] hi);
    return (i < 16) ? lo[2*(i%16) +: 2] : hi[2*(i%16) +: 2];
  endfunction

  function automatic logic soft_reduce(input logic [15:0] f, input logic [15:0] p,
                                       input logic [15:0] m, input logic pol);
    return (|((f ^ p) & m)) ^ pol;
  endfunction

  // Lowest number wins ties because the scan runs downward with >=
  function automatic pic_pkg::pic_sel_type pick(input logic [31:0] e,
                                                input logic [31:0][2:0] lv);
    pic_pkg::pic_sel_type s;
    s = '0;
    for (int i = 31; i >= 0; i--)
      if (e[i] && lv[i] >= s.level)
      begin
        s.valid = 1'b1;
        s.cause = 5'(i);
        s.level = lv[i];
      end
    return s;
  endfunction

  // AXI write channel: address and data taken in either order
  assign do_write    = aw_have_ff && w_have_ff && !s_axi_bvalid;
  assign nxt_aw_have = aw_have_ff ? !do_write : (s_axi_awvalid && s_axi_awready);
  assign nxt_w_have  = w_have_ff ? !do_write : (s_axi_wvalid && s_axi_wready);
  assign nxt_rvalid  = s_axi_rvalid ? !s_axi_rready : (s_axi_arvalid && s_axi_arready);
  assign wmask       = merge(`PIC_RST_WORD, 32'hFFFF_FFFF, w_ff.strb);

  function automatic logic mapped(input logic [15:0] a);
    logic [15:0] b;
    b = {a[15:2], 2'h0};
    case (b)
      `PIC_OFS_DETECT_EN, `PIC_OFS_MODE_LOW, `PIC_OFS_MODE_HIGH, `PIC_OFS_GLOBAL_MASK,
      `PIC_OFS_EDGE_CLEAR, `PIC_OFS_PENDING, `PIC_OFS_CUR_STATUS, `PIC_OFS_FLAG_DIRECT,
      `PIC_OFS_FLAG_SETCLR, `PIC_OFS_FLAG_POL, `PIC_OFS_SOFT_CTRL, `PIC_OFS_MASK_INT,
      `PIC_OFS_MASK_EXT: return 1'b1;
      default: return is_lvl_addr(b);
    endcase
  endfunction

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      aw_ff         <= '0;
      w_ff          <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PIC_RESP_OKAY;
    end
    else
    begin
      aw_have_ff    <= nxt_aw_have;
      w_have_ff     <= nxt_w_have;
      s_axi_awready <= !nxt_aw_have;
      s_axi_wready  <= !nxt_w_have;
      if (s_axi_awvalid && s_axi_awready)
        aw_ff <= '{addr: s_axi_awaddr, from_core: aw_from_core};
      if (s_axi_wvalid && s_axi_wready)
        w_ff <= '{data: s_axi_wdata, strb: s_axi_wstrb};
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_ff.addr) ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      det_en_ff    <= 1'b0;
      mode_lo_ff   <= `PIC_RST_WORD;
      mode_hi_ff   <= `PIC_RST_WORD;
      level_ff     <= '0;
      gmask_ff     <= 3'h0;
      spol_ff      <= 16'h0000;
      smask_int_ff <= 16'h0000;
      smask_ext_ff <= 16'h0000;
      sctrl_ff     <= 3'h0;
    end
    else if (do_write)
    begin
      case ({aw_ff.addr[15:2], 2'h0})
        `PIC_OFS_DETECT_EN:   det_en_ff <= 1'(merge(32'(det_en_ff), w_ff.data, w_ff.strb));
        `PIC_OFS_MODE_LOW:    mode_lo_ff <= merge(mode_lo_ff, w_ff.data, w_ff.strb);
        `PIC_OFS_MODE_HIGH:   mode_hi_ff <= merge(mode_hi_ff, w_ff.data, w_ff.strb);
        `PIC_OFS_GLOBAL_MASK: gmask_ff <= 3'(merge(32'(gmask_ff), w_ff.data, w_ff.strb));
        `PIC_OFS_FLAG_POL:    spol_ff <= 16'(merge(32'(spol_ff), w_ff.data, w_ff.strb));
        `PIC_OFS_SOFT_CTRL:   sctrl_ff <= 3'(merge(32'(sctrl_ff), w_ff.data, w_ff.strb));
        `PIC_OFS_MASK_INT:    smask_int_ff <= 16'(merge(32'(smask_int_ff), w_ff.data, w_ff.strb));
        `PIC_OFS_MASK_EXT:    smask_ext_ff <= 16'(merge(32'(smask_ext_ff), w_ff.data, w_ff.strb));
        default:
          if (is_lvl_addr(aw_ff.addr))
            for (int k = 0; k < 4; k++)
              if (w_ff.strb[k])
                level_ff[{lvl_reg(aw_ff.addr), 2'(k)}] <= w_ff.data[k*8 +: 3];
      endcase
    end
  end

  // Shared 16-bit flag store with two write views
  always_ff @(posedge clk)
  begin
    if (reset)
      sflag_ff <= 16'h0000;
    else if (do_write && {aw_ff.addr[15:2], 2'h0} == `PIC_OFS_FLAG_DIRECT)
      sflag_ff <= 16'(merge(32'(sflag_ff), w_ff.data, w_ff.strb));
    else if (do_write && {aw_ff.addr[15:2], 2'h0} == `PIC_OFS_FLAG_SETCLR)
    begin
      if (aw_ff.from_core)
        sflag_ff <= sflag_ff | (w_ff.data[15:0] & wmask[15:0]);
      else
        sflag_ff <= sflag_ff & ~(w_ff.data[15:0] & wmask[15:0]);
    end
  end

  // Soft request outputs; the pin only drives in external arbiter mode
  assign ext_val = soft_reduce(sflag_ff, spol_ff, smask_ext_ff, sctrl_ff[`PIC_CTRL_EXTERNAL_OUT_POLARITY_BIT]);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      soft_int_req     <= 1'b0;
      soft_req_pin_out <= 1'b0;
      soft_req_pin_oe  <= 1'b0;
    end
    else
    begin
      soft_int_req <= soft_reduce(sflag_ff, spol_ff, smask_int_ff,
                                  sctrl_ff[`PIC_CTRL_INTERNAL_OUT_POLARITY_BIT]);
      if (sctrl_ff[`PIC_CTRL_OD_BIT])
      begin
        soft_req_pin_out <= 1'b0;
        soft_req_pin_oe  <= ext_arbiter_mode && !ext_val;
      end
      else
      begin
        soft_req_pin_out <= ext_val;
        soft_req_pin_oe  <= ext_arbiter_mode;
      end
    end
  end

  // Synchronisers run through reset so the strap is settled at release
  always_ff @(posedge clk)
  begin
    pin_s1_ff  <= ext_int_pin;
    pin_s2_ff  <= pin_s1_ff;
    boot_s1_ff <= boot_data7;
    boot_s2_ff <= boot_s1_ff;
  end

  // Timer strap taken once, at the first edge after reset release
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tdis_ff      <= 1'b0;
      tdis_done_ff <= 1'b0;
    end
    else if (!tdis_done_ff)
    begin
      tdis_ff      <= boot_s2_ff;
      tdis_done_ff <= 1'b1;
    end
  end

  // Source map and detection
  always_comb
  begin
    src_raw = periph_req;
    src_raw[7:2] = pin_s2_ff;
    if (pin_mux_net[0])
      src_raw[`PIC_SRC_SHARED_B] = network_ctrl_b_req;
    if (pin_mux_net[1])
      src_raw[`PIC_SRC_SHARED_A] = network_ctrl_a_req;
    src_raw[`PIC_SRC_SOFT] = soft_int_req;
    src_raw[`PIC_SRC_RESERVED] = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      case (pic_pkg::pic_mode_type'(mode_of(i, mode_lo_ff, mode_hi_ff)))
        pic_pkg::PIC_LOW:  lvl_hit[i] = !src_raw[i];
        pic_pkg::PIC_HIGH: lvl_hit[i] = src_raw[i];
        default:           lvl_hit[i] = 1'b0;
      endcase
      is_edge[i]  = mode_of(i, mode_lo_ff, mode_hi_ff) >= 2'(pic_pkg::PIC_FALL);
      edge_set[i] = is_edge[i] && det_en_ff &&
                    (mode_of(i, mode_lo_ff, mode_hi_ff) == 2'(pic_pkg::PIC_RISE) ?
                     (src_raw[i] && !prev_ff[i]) : (!src_raw[i] && prev_ff[i]));
      clr_vec[i]  = do_write && {aw_ff.addr[15:2], 2'h0} == `PIC_OFS_EDGE_CLEAR &&
                    ((w_ff.data[`PIC_EDC_EN_A_BIT] && w_ff.data[4:0] == 5'(i)) ||
                     (w_ff.data[`PIC_EDC_EN_B_BIT] &&
                      w_ff.data[`PIC_EDC_SRC_B_LSB +: 5] == 5'(i)));
    end
    lvl_hit[`PIC_SRC_RESERVED] = 1'b0;
  end

  // Edge latch: a new edge wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prev_ff <= `PIC_RST_WORD;
      edge_ff <= `PIC_RST_WORD;
      pend_ff <= `PIC_RST_WORD;
    end
    else
    begin
      prev_ff <= src_raw;
      edge_ff <= (edge_set | (edge_ff & ~clr_vec)) & is_edge;
      pend_ff <= det_en_ff ? (lvl_hit | (edge_ff & is_edge)) : `PIC_RST_WORD;
    end
  end

  // Arbitration
  always_comb
  begin
    for (int i = 0; i < 32; i++)
      elig[i] = pend_ff[i] && level_ff[i] > gmask_ff;
    best  = pick(elig, level_ff);
    rearb = !stat_ff.valid ||
            (best.valid && best.level > stat_ff.level) ||
            level_ff[stat_ff.cause] < stat_ff.level ||
            !pend_ff[stat_ff.cause];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      stat_ff <= '0;
    else if (rearb)
      stat_ff <= best;
  end

  // Mask change drops the flag without moving the selection
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      flag_ff           <= 1'b0;
      core_pending_bits <= 6'h00;
    end
    else
    begin
      flag_ff <= stat_ff.valid && stat_ff.level > gmask_ff && det_en_ff;
      core_pending_bits[2] <= flag_ff;
      if (tdis_ff)
        core_pending_bits[7:3] <= stat_ff.cause;
      else
        core_pending_bits[7:3] <= {core_timer_irq, stat_ff.cause[3:0]};
    end
  end

  // Read channel
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `PIC_RST_WORD;
      s_axi_rresp   <= `PIC_RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid  <= nxt_rvalid;
      s_axi_arready <= !nxt_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rresp <= mapped(s_axi_araddr) ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
        case ({s_axi_araddr[15:2], 2'h0})
          `PIC_OFS_DETECT_EN:   s_axi_rdata <= 32'(det_en_ff);
          `PIC_OFS_MODE_LOW:    s_axi_rdata <= mode_lo_ff;
          `PIC_OFS_MODE_HIGH:   s_axi_rdata <= mode_hi_ff;
          `PIC_OFS_GLOBAL_MASK: s_axi_rdata <= 32'(gmask_ff);
          `PIC_OFS_PENDING:     s_axi_rdata <= pend_ff;
          `PIC_OFS_CUR_STATUS:
            s_axi_rdata <= (32'(flag_ff) << `PIC_CS_FLAG_BIT) |
                           (32'(stat_ff.level) << `PIC_CS_LEVEL_LSB) | 32'(stat_ff.cause);
          `PIC_OFS_FLAG_DIRECT, `PIC_OFS_FLAG_SETCLR: s_axi_rdata <= 32'(sflag_ff);
          `PIC_OFS_FLAG_POL:    s_axi_rdata <= 32'(spol_ff);
          `PIC_OFS_SOFT_CTRL:   s_axi_rdata <= 32'(sctrl_ff);
          `PIC_OFS_MASK_INT:    s_axi_rdata <= 32'(smask_int_ff);
          `PIC_OFS_MASK_EXT:    s_axi_rdata <= 32'(smask_ext_ff);
          default:
            s_axi_rdata <= is_lvl_addr(s_axi_araddr) ?
                           lvl_image(level_ff, lvl_reg(s_axi_araddr)) : `PIC_RST_WORD;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_reserved_quiet;
    pend_ff[`PIC_SRC_RESERVED] == 1'b0;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved source pending");

  property p_detect_off;
    !det_en_ff [*2] |=> !flag_ff && pend_ff == 32'h0000_0000;
  endproperty
  a_detect_off: assert property (p_detect_off) else $error("request seen while disabled");

  property p_higher_wins;
    stat_ff.valid && best.valid && best.level > stat_ff.level
      |=> stat_ff.level == $past(best.level) && stat_ff.cause == $past(best.cause);
  endproperty
  a_higher_wins: assert property (p_higher_wins) else $error("higher level not taken");

  property p_equal_keeps;
    stat_ff.valid && pend_ff[stat_ff.cause] && level_ff[stat_ff.cause] >= stat_ff.level &&
      !(best.valid && best.level > stat_ff.level) |=> $stable(stat_ff);
  endproperty
  a_equal_keeps: assert property (p_equal_keeps) else $error("selection moved without cause");

  property p_winner_eligible;
    rearb && best.valid |=> stat_ff.valid && $past(level_ff[best.cause]) > $past(gmask_ff);
  endproperty
  a_winner_eligible: assert property (p_winner_eligible) else $error("masked winner");

  property p_mask_drops_flag;
    stat_ff.valid && gmask_ff >= stat_ff.level |=> !flag_ff ##1 !core_pending_bits[2];
  endproperty
  a_mask_drops_flag: assert property (p_mask_drops_flag) else $error("flag not masked");

  property p_cause_bits;
    tdis_ff |=> core_pending_bits[7:3] == $past(stat_ff.cause);
  endproperty
  a_cause_bits: assert property (p_cause_bits) else $error("cause not on pending bits");

  property p_timer_bits;
    !tdis_ff |=> core_pending_bits[7:3] == {$past(core_timer_irq), $past(stat_ff.cause[3:0])};
  endproperty
  a_timer_bits: assert property (p_timer_bits) else $error("timer not on pending bit");

  property p_edge_cleared;
    (clr_vec & ~edge_set) != 32'h0000_0000
      |=> (edge_ff & $past(clr_vec) & ~$past(edge_set)) == 32'h0000_0000;
  endproperty
  a_edge_cleared: assert property (p_edge_cleared) else $error("edge not cleared");

  property p_other_clears;
    do_write && !aw_ff.from_core && {aw_ff.addr[15:2], 2'h0} == `PIC_OFS_FLAG_SETCLR
      |=> (sflag_ff & $past(w_ff.data[15:0]) & $past(wmask[15:0])) == 16'h0000;
  endproperty
  a_other_clears: assert property (p_other_clears) else $error("flag bit not cleared");

  property p_soft_idle;
    smask_int_ff == 16'h0000 [*2] |-> soft_int_req == $past(sctrl_ff[`PIC_CTRL_INTERNAL_OUT_POLARITY_BIT]);
  endproperty
  a_soft_idle: assert property (p_soft_idle) else $error("soft request without mask");

  c_preempt:    cover property (stat_ff.valid && best.valid && best.level > stat_ff.level);
  c_flag_rise:  cover property (!flag_ff ##1 flag_ff);
  c_edge_clear: cover property (clr_vec != 32'h0000_0000 && edge_ff != 32'h0000_0000);
  c_lowered:    cover property (stat_ff.valid && level_ff[stat_ff.cause] < stat_ff.level);
endmodule
